// ---- include/hdlc_tx_pkg.sv ----
/*
 * Shared constants and types for the transmit data-link buffer and count control.
 * Assumes one 100 MHz clock and a synchronous, active-high reset in every user.
 */
`default_nettype none

package hdlc_tx_pkg;
    // Host register layout: bit 7 selects or reports a buffer, bits 6..0 hold the count.
    localparam int unsigned DATA_W = 8;
    localparam int unsigned COUNT_W = 7;
    localparam int unsigned SEL_BIT = 7;
    localparam logic [6:0] COUNT_RESET = 7'h00;
    localparam logic [6:0] COUNT_ZERO = 7'h00;
    localparam logic [6:0] COUNT_ONE = 7'h01;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Message buffer locations inside the channel's address space.
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] BUF0_OFFSET = 12'h600;
    localparam logic [11:0] BUF1_OFFSET = 12'h700;
    localparam logic [11:0] ADDR_RESET = 12'h000;

    // Length in octets of one bit-oriented message held in a buffer.
    localparam int unsigned BOS_LEN_DEFAULT = 2;

    // Frame check sequence: reflected CCITT polynomial, preset to all ones.
    localparam logic [15:0] FCS_INIT = 16'hffff;
    localparam logic [15:0] FCS_POLY = 16'h8408;

    // Transmit engine states, one-hot.
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_DATA = 8'h04,
        ST_SEND = 8'h08,
        ST_FCS_PREP = 8'h10,
        ST_FCS_LO = 8'h20,
        ST_FCS_HI = 8'h40,
        ST_DONE = 8'h80
    } tx_state_t;
endpackage : hdlc_tx_pkg

`default_nettype wire

// ---- hdl/hdlc_fcs16.sv ----
/*
 * Sixteen-bit frame check sequence accumulator for outbound message-oriented frames.
 * Assumes the caller clears it before a frame and pulses update once per accepted octet.
 */
`default_nettype none

module hdlc_fcs16 (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic update,
    input wire logic [7:0] data,
    output logic [15:0] fcs
);
    logic [15:0] next_fcs;

    // One octet through the reflected polynomial, least significant bit first.
    function automatic logic [15:0] fcs_step(input logic [15:0] crc, input logic [7:0] octet);
        logic [15:0] acc;
        acc = crc ^ {8'h00, octet};
        for (int i = 0; i < 8; i++) begin
            acc = acc[0] ? ((acc >> 1) ^ hdlc_tx_pkg::FCS_POLY) : (acc >> 1);
        end
        return acc;
    endfunction : fcs_step

    // Clear has priority so a new frame never inherits a stale remainder.
    always_comb begin
        next_fcs = fcs;
        if (clear) begin
            next_fcs = hdlc_tx_pkg::FCS_INIT;
        end else if (update) begin
            next_fcs = fcs_step(fcs, data);
        end
    end

    // The accumulator only registers its next value.
    always_ff @(posedge clk) begin
        if (reset) begin
            fcs <= hdlc_tx_pkg::FCS_INIT;
        end else begin
            fcs <= next_fcs;
        end
    end
endmodule : hdlc_fcs16

`default_nettype wire

// ---- hdl/hdlc_tx_buffer_count_ctrl.sv ----
/*
 * Double-buffer selection and count control of the second transmit data-link controller.
 * Assumes the host register strobe, mode bits, buffer memory and byte sink share clk,
 * and that the buffer memory returns read data one cycle after it samples an address.
 */
`default_nettype none

// Function
// - Writing the select bit makes buffer 0 or buffer 1 the one read and sent.
// - Reading the select bit reports the next free buffer, at 0x600 or 0x700.
// - While one buffer still holds an unsent message, the read value names the other.
// - Bit-oriented mode sends the message count times, then signals end of transfer and stops.
// - Bit-oriented mode with count zero repeats until the other buffer is queued and never ends on a count.
// - Message-oriented count is octets including header and control, excluding the check sequence.
// - Mode input low selects bit-oriented sending, high selects message-oriented sending.
// - With checksum append enabled, check sequence octets follow each non-empty message-oriented message.
module hdlc_tx_buffer_count_ctrl #(
    parameter int unsigned BOS_LEN = hdlc_tx_pkg::BOS_LEN_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic signaling_type_select,
    input wire logic tx_checksum_append_enable,
    output logic buf_rd_en,
    output logic [11:0] buf_rd_addr,
    input wire logic [7:0] buf_rd_data,
    output logic tx_byte_valid,
    input wire logic tx_byte_ready,
    output logic [7:0] tx_byte,
    output logic tx_end_of_transfer
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    hdlc_tx_pkg::tx_state_t state, next_state;
    logic [1:0] busy, next_busy;
    logic [1:0][6:0] buf_count, next_buf_count;
    logic [6:0] last_wr_count, next_last_wr_count;
    logic cur_buf, next_cur_buf;
    logic cur_mos, next_cur_mos;
    logic cur_fcs, next_cur_fcs;
    logic [6:0] cur_count, next_cur_count;
    logic [6:0] idx, next_idx;
    logic [6:0] reps, next_reps;
    logic [6:0] idx_inc, reps_inc;
    logic [11:0] next_buf_rd_addr;
    logic [7:0] next_tx_byte, next_reg_rdata;
    logic next_eot, release_buf, pick, last_octet;
    logic fcs_clear, fcs_update;
    logic [15:0] fcs_value;
    logic [7:0] fcs_lo_expect;

    // Byte address of an octet inside a message buffer.
    function automatic logic [11:0] buf_addr(input logic sel, input logic [6:0] index);
        return (sel ? hdlc_tx_pkg::BUF1_OFFSET : hdlc_tx_pkg::BUF0_OFFSET) + {5'h00, index};
    endfunction : buf_addr

    // Next free buffer; with both full, the one being sent frees first.
    function automatic logic avail_buf(input logic [1:0] full, input logic active);
        unique case (full)
            2'b01: return 1'b1;
            2'b10: return 1'b0;
            2'b11: return active;
            default: return 1'b0;
        endcase
    endfunction : avail_buf

    hdlc_fcs16 u_fcs (
        .clk(clk),
        .reset(reset),
        .clear(fcs_clear),
        .update(fcs_update),
        .data(tx_byte),
        .fcs(fcs_value)
    );

    assign idx_inc = idx + hdlc_tx_pkg::COUNT_ONE;
    assign reps_inc = reps + hdlc_tx_pkg::COUNT_ONE;
    assign last_octet = cur_mos ? (idx_inc == cur_count) : (idx_inc == 7'(BOS_LEN));
    assign pick = (busy == 2'b11) ? ~cur_buf : busy[1];
    assign fcs_lo_expect = ~fcs_value[7:0];

    // Handshake outputs decode straight from the state register.
    assign buf_rd_en = (state == hdlc_tx_pkg::ST_ADDR);
    assign tx_byte_valid = (state == hdlc_tx_pkg::ST_SEND) || (state == hdlc_tx_pkg::ST_FCS_LO)
                           || (state == hdlc_tx_pkg::ST_FCS_HI);

    // Transmit engine: fetch each octet, hand it out, then close the message.
    always_comb begin
        next_state = state;
        next_cur_buf = cur_buf;
        next_cur_mos = cur_mos;
        next_cur_fcs = cur_fcs;
        next_cur_count = cur_count;
        next_idx = idx;
        next_reps = reps;
        next_buf_rd_addr = buf_rd_addr;
        next_tx_byte = tx_byte;
        next_eot = 1'b0;
        release_buf = 1'b0;
        fcs_clear = 1'b0;
        fcs_update = 1'b0;
        unique case (state)
            hdlc_tx_pkg::ST_IDLE: begin
                if (busy != 2'b00) begin
                    next_cur_buf = pick;
                    next_cur_mos = signaling_type_select;
                    next_cur_fcs = tx_checksum_append_enable;
                    next_cur_count = buf_count[pick];
                    next_idx = hdlc_tx_pkg::COUNT_ZERO;
                    next_reps = hdlc_tx_pkg::COUNT_ZERO;
                    next_buf_rd_addr = buf_addr(pick, hdlc_tx_pkg::COUNT_ZERO);
                    fcs_clear = 1'b1;
                    // An empty message-oriented message has nothing to send.
                    if (signaling_type_select && buf_count[pick] == hdlc_tx_pkg::COUNT_ZERO) begin
                        next_state = hdlc_tx_pkg::ST_DONE;
                    end else begin
                        next_state = hdlc_tx_pkg::ST_ADDR;
                    end
                end
            end
            hdlc_tx_pkg::ST_ADDR: begin
                next_state = hdlc_tx_pkg::ST_DATA;
            end
            hdlc_tx_pkg::ST_DATA: begin
                next_tx_byte = buf_rd_data;
                next_state = hdlc_tx_pkg::ST_SEND;
            end
            hdlc_tx_pkg::ST_SEND: begin
                if (tx_byte_ready) begin
                    fcs_update = cur_mos;
                    if (!last_octet) begin
                        next_idx = idx_inc;
                        next_buf_rd_addr = buf_addr(cur_buf, idx_inc);
                        next_state = hdlc_tx_pkg::ST_ADDR;
                    end else if (cur_mos) begin
                        next_idx = idx_inc;
                        next_state = cur_fcs ? hdlc_tx_pkg::ST_FCS_PREP : hdlc_tx_pkg::ST_DONE;
                    end else begin
                        next_reps = reps_inc;
                        next_idx = hdlc_tx_pkg::COUNT_ZERO;
                        next_buf_rd_addr = buf_addr(cur_buf, hdlc_tx_pkg::COUNT_ZERO);
                        if (cur_count != hdlc_tx_pkg::COUNT_ZERO && reps_inc == cur_count) begin
                            next_state = hdlc_tx_pkg::ST_DONE;
                        end else if (cur_count == hdlc_tx_pkg::COUNT_ZERO && busy[~cur_buf]) begin
                            // Endless repetition yields to a newer message without an end event.
                            release_buf = 1'b1;
                            next_state = hdlc_tx_pkg::ST_IDLE;
                        end else begin
                            next_state = hdlc_tx_pkg::ST_ADDR;
                        end
                    end
                end
            end
            hdlc_tx_pkg::ST_FCS_PREP: begin
                // One spare cycle lets the last data octet settle into the accumulator.
                next_tx_byte = fcs_lo_expect;
                next_state = hdlc_tx_pkg::ST_FCS_LO;
            end
            hdlc_tx_pkg::ST_FCS_LO: begin
                if (tx_byte_ready) begin
                    next_tx_byte = ~fcs_value[15:8];
                    next_state = hdlc_tx_pkg::ST_FCS_HI;
                end
            end
            hdlc_tx_pkg::ST_FCS_HI: begin
                if (tx_byte_ready) begin
                    next_state = hdlc_tx_pkg::ST_DONE;
                end
            end
            hdlc_tx_pkg::ST_DONE: begin
                release_buf = 1'b1;
                next_eot = 1'b1;
                next_state = hdlc_tx_pkg::ST_IDLE;
            end
            default: begin
                next_state = hdlc_tx_pkg::ST_IDLE;
            end
        endcase
    end

    // Host register: a write queues a buffer; the read image is refreshed every cycle.
    always_comb begin
        next_busy = busy;
        next_buf_count = buf_count;
        next_last_wr_count = last_wr_count;
        if (release_buf) begin
            next_busy[cur_buf] = 1'b0;
        end
        // A write in the same cycle as the release wins, so a fresh message is not lost.
        if (reg_wr) begin
            next_busy[reg_wdata[hdlc_tx_pkg::SEL_BIT]] = 1'b1;
            next_buf_count[reg_wdata[hdlc_tx_pkg::SEL_BIT]] = reg_wdata[hdlc_tx_pkg::COUNT_W-1:0];
            next_last_wr_count = reg_wdata[hdlc_tx_pkg::COUNT_W-1:0];
        end
        next_reg_rdata = {avail_buf(busy, cur_buf), last_wr_count};
    end

    // All state of the block except the check sequence accumulator registers here.
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= hdlc_tx_pkg::ST_IDLE;
            busy <= 2'b00;
            buf_count <= {hdlc_tx_pkg::COUNT_RESET, hdlc_tx_pkg::COUNT_RESET};
            last_wr_count <= hdlc_tx_pkg::COUNT_RESET;
            cur_buf <= 1'b0;
            cur_mos <= 1'b0;
            cur_fcs <= 1'b0;
            cur_count <= hdlc_tx_pkg::COUNT_RESET;
            idx <= hdlc_tx_pkg::COUNT_RESET;
            reps <= hdlc_tx_pkg::COUNT_RESET;
            buf_rd_addr <= hdlc_tx_pkg::ADDR_RESET;
            tx_byte <= hdlc_tx_pkg::RDATA_RESET;
            tx_end_of_transfer <= 1'b0;
            reg_rdata <= hdlc_tx_pkg::RDATA_RESET;
        end else begin
            state <= next_state;
            busy <= next_busy;
            buf_count <= next_buf_count;
            last_wr_count <= next_last_wr_count;
            cur_buf <= next_cur_buf;
            cur_mos <= next_cur_mos;
            cur_fcs <= next_cur_fcs;
            cur_count <= next_cur_count;
            idx <= next_idx;
            reps <= next_reps;
            buf_rd_addr <= next_buf_rd_addr;
            tx_byte <= next_tx_byte;
            tx_end_of_transfer <= next_eot;
            reg_rdata <= next_reg_rdata;
        end
    end

    // A write to an idle block starts reading the selected buffer two cycles later; an empty message ends at once.
    property p_sel_start;
        (reg_wr && state == hdlc_tx_pkg::ST_IDLE && busy == 2'b00) |-> ##2
            (state == (($past(signaling_type_select) && $past(reg_wdata[hdlc_tx_pkg::COUNT_W-1:0], 2)
                == hdlc_tx_pkg::COUNT_ZERO) ? hdlc_tx_pkg::ST_DONE : hdlc_tx_pkg::ST_ADDR)
            && buf_rd_addr == buf_addr($past(reg_wdata[hdlc_tx_pkg::SEL_BIT], 2), hdlc_tx_pkg::COUNT_ZERO));
    endproperty
    a_sel_start: assert property (p_sel_start) else $error("selected buffer not read");

    property p_avail_one;
        (busy == 2'b01) |=> (reg_rdata[7] == 1'b1);
    endproperty
    a_avail_one: assert property (p_avail_one) else $error("buffer 1 not reported free");

    property p_avail_zero;
        (busy == 2'b10) |=> (reg_rdata[7] == 1'b0);
    endproperty
    a_avail_zero: assert property (p_avail_zero) else $error("buffer 0 not reported free");

    property p_bos_count;
        (state == hdlc_tx_pkg::ST_DONE && !cur_mos) |->
            (reps == cur_count) ##1 (tx_end_of_transfer && state == hdlc_tx_pkg::ST_IDLE);
    endproperty
    a_bos_count: assert property (p_bos_count) else $error("repetition count mismatch");

    property p_bos_forever;
        (state != hdlc_tx_pkg::ST_IDLE && !cur_mos && cur_count == 7'h00) |=> !tx_end_of_transfer [*2];
    endproperty
    a_bos_forever: assert property (p_bos_forever) else $error("endless repetition ended");

    property p_mos_len;
        (state == hdlc_tx_pkg::ST_DONE && cur_mos) |-> (idx == cur_count);
    endproperty
    a_mos_len: assert property (p_mos_len) else $error("octet count mismatch");

    property p_mode_latch;
        (state == hdlc_tx_pkg::ST_IDLE && busy != 2'b00) |=> (cur_mos == $past(signaling_type_select));
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not taken at start");

    property p_fcs_append;
        (state == hdlc_tx_pkg::ST_SEND && tx_byte_ready && cur_mos && cur_fcs && idx_inc == cur_count) |=>
            (state == hdlc_tx_pkg::ST_FCS_PREP) ##1
            (state == hdlc_tx_pkg::ST_FCS_LO && tx_byte_valid && tx_byte == $past(fcs_lo_expect));
    endproperty
    a_fcs_append: assert property (p_fcs_append) else $error("check sequence not appended");
endmodule : hdlc_tx_buffer_count_ctrl

`default_nettype wire

// ---- verif/link_sink_model.sv ----
/*
 * Remote data-link sink that takes outbound octets from the transmit controller.
 * Assumes the device clock and its synchronous, active-high reset.
 */
`default_nettype none

module link_sink_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic tx_byte_valid,
    output logic tx_byte_ready,
    output logic [15:0] octets_taken
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tx_byte_ready = 1'b0;
        octets_taken = 16'h0000;
    end

    // A slow sink stalls at random, so the device must hold each octet until it is taken.
    always @(posedge clk) begin
        if (tx_byte_valid === 1'b1 && tx_byte_ready === 1'b1) begin
            octets_taken <= #1 octets_taken + 16'h0001;
        end
        tx_byte_ready <= #1 !reset && (!slow || $urandom_range(1) == 1);
    end
endmodule : link_sink_model

`default_nettype wire

// ---- verif/hdlc_tx_buffer_count_ctrl_tb.sv ----
/*
 * Self-checking bench for the transmit buffer and count control, with a queue model.
 * Assumes the buffer memory answers one cycle after a fetch, as the bench models it.
 */
`default_nettype none

module hdlc_tx_buffer_count_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned BLEN = 3;
    logic clk, reset, reg_wr, mo, chk, slow, sel;
    logic [7:0] reg_wdata, reg_rdata, buf_rd_data, tx_byte;
    logic buf_rd_en, tx_byte_valid, tx_byte_ready, tx_end_of_transfer;
    logic [11:0] buf_rd_addr;
    logic [15:0] octets_taken;
    logic [7:0] mem [0:4095];
    logic [7:0] got[$], exp_q[$];
    int fails, samples_checked, end_n, total, n;

    hdlc_tx_buffer_count_ctrl #(.BOS_LEN(BLEN)) dut_u (.clk(clk), .reset(reset), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .signaling_type_select(mo),
        .tx_checksum_append_enable(chk), .buf_rd_en(buf_rd_en), .buf_rd_addr(buf_rd_addr),
        .buf_rd_data(buf_rd_data), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
        .tx_byte(tx_byte), .tx_end_of_transfer(tx_end_of_transfer));
    link_sink_model sink_u (.clk(clk), .reset(reset), .slow(slow), .tx_byte_valid(tx_byte_valid),
        .tx_byte_ready(tx_byte_ready), .octets_taken(octets_taken));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Buffer memory with a one-cycle synchronous read.
    always @(posedge clk) begin
        if (buf_rd_en === 1'b1) buf_rd_data <= #1 mem[buf_rd_addr];
    end

    // Octets and end pulses are captured exactly as the sink sees them.
    always @(posedge clk) begin
        if (tx_byte_valid === 1'b1 && tx_byte_ready === 1'b1) got.push_back(tx_byte);
        if (tx_end_of_transfer === 1'b1) end_n++;
    end

    task automatic print_verdict;
        $display("checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic cmp_octet(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: octet %h, model %h", $time, g, e);
        end
    endtask : cmp_octet

    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: read image %h, model %h", $time, g, e);
        end
    endtask : cmp_reg

    task automatic cmp_count(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: count %0d, model %0d", $time, g, e);
        end
    endtask : cmp_count

    // Inverted reflected CRC over the data octets; computed here, independent of the design.
    function automatic logic [15:0] crc(input logic [11:0] base, input int len);
        logic [15:0] c;
        c = hdlc_tx_pkg::FCS_INIT;
        for (int i = 0; i < len; i++) begin
            c = c ^ {8'h00, mem[base + i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ hdlc_tx_pkg::FCS_POLY : c >> 1;
        end
        return ~c;
    endfunction : crc

    // Fills a buffer at random and appends what the link should carry for it.
    task automatic load(input logic s, input int cnt);
        logic [11:0] base;
        logic [15:0] c;
        base = s ? hdlc_tx_pkg::BUF1_OFFSET : hdlc_tx_pkg::BUF0_OFFSET;
        for (int i = 0; i < (mo ? cnt : BLEN); i++) mem[base + i] = 8'($urandom);
        c = crc(base, cnt);
        if (mo) begin
            for (int i = 0; i < cnt; i++) exp_q.push_back(mem[base + i]);
            if (chk && cnt > 0) exp_q.push_back(c[7:0]);
            if (chk && cnt > 0) exp_q.push_back(c[15:8]);
        end else begin
            for (int r = 0; r < cnt * BLEN; r++) exp_q.push_back(mem[base + r % BLEN]);
        end
    endtask : load

    task automatic wr(input logic [7:0] v);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_wdata = v;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask : wr

    // Bounded wait for end pulses (kind 0) or captured octets (kind 1).
    task automatic wait_cond(input int kind, input int cnt);
        int i;
        for (i = 0; i < 4000; i++) begin
            if (kind == 0 ? end_n >= cnt : got.size() >= cnt) break;
            @(posedge clk);
        end
        if (i == 4000) begin
            fails++;
            $display("unexpected at %0t: wait ran out", $time);
            print_verdict();
        end
        #1;
    endtask : wait_cond

    // Compares the whole captured stream with the model once the expected ends arrived.
    task automatic settle(input int ends);
        wait_cond(0, ends);
        repeat (2) @(posedge clk);
        #1;
        cmp_count(got.size(), exp_q.size());
        for (int i = 0; i < exp_q.size() && i < got.size(); i++) cmp_octet(got[i], exp_q[i]);
        cmp_count(end_n, ends);
        total += exp_q.size();
        got.delete();
        exp_q.delete();
        end_n = 0;
    endtask : settle

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        {mo, chk, slow, sel} = 4'h0;
        buf_rd_data = 8'h00;
        {fails, samples_checked, end_n, total} = '0;
        void'($urandom(32'h8104_491a));
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        cmp_reg(reg_rdata, 8'h00);
        // Message frames in both buffers, checksum on and off, prompt and slow sink, one empty.
        for (int k = 0; k < 8; k++) begin
            n = (k == 7) ? 0 : $urandom_range(6, 1);
            {slow, chk, sel} = 3'(k);
            mo = 1'b1;
            load(sel, n);
            wr({sel, n[6:0]});
            repeat (2) @(posedge clk);
            #1;
            if (n != 0) cmp_reg(reg_rdata, {~sel, n[6:0]});
            settle(1);
            cmp_reg(reg_rdata, {1'b0, n[6:0]});
            $display("message test %0d done", k);
        end
        // Repeated messages; the checksum enable must add nothing here.
        {mo, chk} = 2'b01;
        for (int k = 1; k < 3; k++) begin
            load(k[0], k);
            wr({k[0], 7'(k)});
            settle(1);
        end
        $display("repeat test done");
        // Both buffers queued; the image names the buffer in flight.
        {mo, chk, slow} = 3'b111;
        load(1'b0, 3);
        wr(8'h03);
        load(1'b1, 2);
        wr(8'h82);
        repeat (2) @(posedge clk);
        #1;
        cmp_reg(reg_rdata, 8'h02);
        settle(2);
        cmp_count(octets_taken, total);
        $display("queued test done");
        // Endless repetition, later displaced by the other buffer.
        {mo, chk, slow} = 3'b000;
        load(1'b0, 4);
        wr(8'h00);
        wait_cond(1, 4 * BLEN);
        cmp_count(end_n, 0);
        for (int i = 0; i < 4 * BLEN; i++) cmp_octet(got[i], exp_q[i]);
        exp_q.delete();
        load(1'b1, 0);
        wr(8'h81);
        wait_cond(0, 1);
        cmp_count(end_n, 1);
        // The newer buffer's octets close the stream once the endless run has yielded.
        for (int i = 0; i < BLEN; i++) cmp_octet(got[got.size() - BLEN + i], mem[hdlc_tx_pkg::BUF1_OFFSET + i]);
        $display("endless test done");
        print_verdict();
    end
endmodule : hdlc_tx_buffer_count_ctrl_tb

`default_nettype wire
